//--- include/audio_rx_map.vh
// register map, field positions, reset values and widths for the
// playback audio port receiver; assumes a 16-bit register port.
`ifndef AUDIO_RX_MAP_VH
`define AUDIO_RX_MAP_VH

`define ADDR_W 8
`define DATA_W 16
`define ADDR_PORT_CTL0 8'h18
`define ADDR_PORT_CTL1 8'h19
`define ADDR_BCLK_RATE 8'h1a
`define ADDR_FRAME_CTL 8'h1b
`define ADDR_PIN_PULL 8'h7e
`define ADDR_CONV_EN 8'h30
`define ADDR_LAST_SAMPLE 8'h31

`define BIT_EXPAND_EN 1
`define BIT_LAW_SEL 0
`define BIT_BCLK_DIR 6
`define BIT_VARIANT 4
`define BIT_FRAME_DIR 11
`define FRAME_RATE_MSB 10
`define BCLK_DIV_MSB 4
`define PULL_MSB 7

`define RST_BCLK_DIV 5'h04
`define RST_FRAME_RATE 11'h040

`define SAMPLE_W 16
`define PHASE_W 7
`define BITS_PER_WORD 3'h7
`define MU_BIAS 16'h0084
`define A_INV_MASK 8'h55

`endif

//--- core/bclk_divider.v
// bit-clock generator: divides the system clock by a coded ratio,
// half ratios included; assumes i_code is a register output.
`timescale 1ns/1ps
`include "audio_rx_map.vh"
module bclk_divider (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_run,
    input wire [4:0] i_code,
    output reg o_rise,
    output reg o_level
);
    // =========================================
    // ratio in half system-clock cycles
    function [`PHASE_W-1:0] half_ratio;
        input [4:0] code;
        begin
            case (code)
                5'h00: half_ratio = 7'h02;
                5'h01: half_ratio = 7'h03;
                5'h02: half_ratio = 7'h04;
                5'h03: half_ratio = 7'h06;
                5'h04: half_ratio = 7'h08;
                5'h05: half_ratio = 7'h0a;
                5'h06: half_ratio = 7'h0b;
                5'h07: half_ratio = 7'h0c;
                5'h08: half_ratio = 7'h10;
                5'h09: half_ratio = 7'h14;
                5'h0a: half_ratio = 7'h16;
                5'h0b: half_ratio = 7'h18;
                5'h0c: half_ratio = 7'h20;
                5'h0d: half_ratio = 7'h28;
                5'h0e: half_ratio = 7'h2c;
                5'h0f: half_ratio = 7'h30;
                5'h10: half_ratio = 7'h32;
                5'h11: half_ratio = 7'h3c;
                5'h12: half_ratio = 7'h40;
                5'h13: half_ratio = 7'h58;
                5'h14: half_ratio = 7'h60;
                default: half_ratio = 7'h60;
            endcase
        end
    endfunction

    // =========================================
    // phase accumulator, two half-units per edge
    reg [`PHASE_W-1:0] phase_q;
    reg [`PHASE_W-1:0] phase_d;
    reg [`PHASE_W-1:0] ratio;
    reg [`PHASE_W-1:0] sum;
    reg wrap;
    always @* begin
        ratio = half_ratio(i_code);
        sum = phase_q + 7'h02;
        wrap = (sum >= ratio);
        phase_d = wrap ? (sum - ratio) : sum;
        if (!i_run) begin
            phase_d = 7'h00;
            wrap = 1'b0;
        end
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= 7'h00;
            o_rise <= 1'b0;
            o_level <= 1'b0;
        end else begin
            phase_q <= phase_d;
            o_rise <= wrap;
            o_level <= i_run & (phase_d < {1'b0, ratio[`PHASE_W-1:1]});
        end
    end
endmodule // bclk_divider

//--- core/sample_expander.v
// companded byte to left-justified linear sample, combinational;
// assumes the byte still carries the link inversion.
`timescale 1ns/1ps
`include "audio_rx_map.vh"
module sample_expander (
    input wire [7:0] i_code,
    input wire i_expand_en,
    input wire i_law_a,
    output reg [`SAMPLE_W-1:0] o_sample
);
    reg [7:0] x;
    reg [2:0] expo;
    reg [3:0] mant;
    reg [`SAMPLE_W-1:0] t;
    always @* begin
        x = i_law_a ? (i_code ^ `A_INV_MASK) : ~i_code;
        expo = x[6:4];
        mant = x[3:0];
        t = 16'h0000;
        if (!i_expand_en) begin
            o_sample = {i_code, 8'h00};
        end else if (i_law_a) begin
            // segments 0 and 1 share one step, each later segment doubles it
            t = {8'h00, mant, 4'h0};
            if (expo == 3'h0) begin
                t = t + 16'h0008;
            end else begin
                t = (t + 16'h0108) << (expo - 3'h1);
            end
            o_sample = x[7] ? t : (16'h0000 - t);
        end else begin
            t = (({9'h000, mant, 3'h0} + `MU_BIAS) << expo) - `MU_BIAS;
            o_sample = x[7] ? (16'h0000 - t) : t;
        end
    end
endmodule // sample_expander

//--- core/audio_rx_port.v
// playback audio port: clock direction and generation, 8-bit word
// capture and expansion, pin pulls; pins are synchronous to i_clk_sys.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "audio_rx_map.vh"
module audio_rx_port (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [`ADDR_W-1:0] i_addr,
    input wire [`DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [`DATA_W-1:0] o_rdata,
    input wire i_bclk_pin,
    output reg o_bclk_pin,
    output reg o_bclk_oe,
    input wire i_frame_clock_pin,
    output reg o_frame_clock_pin,
    output reg o_frame_clock_oe,
    input wire i_playback_serial_data,
    output reg o_master_clock_pin_pullup,
    output reg o_master_clock_pin_pulldown,
    output reg o_playback_data_pin_pullup,
    output reg o_playback_data_pin_pulldown,
    output reg o_frame_clock_pin_pullup,
    output reg o_frame_clock_pin_pulldown,
    output reg o_bit_clock_pin_pullup,
    output reg o_bit_clock_pin_pulldown,
    output reg [`SAMPLE_W-1:0] o_sample,
    output reg o_sample_valid,
    output reg o_sample_right
);
    // =========================================
    // control registers
    reg expand_en_q;
    reg expand_law_select_q;
    reg bclk_dir_q;
    reg frame_polarity_variant_select_q;
    reg [4:0] bclk_div_q;
    reg frame_dir_q;
    reg [10:0] frame_rate_q;
    reg [7:0] pull_q;
    reg [1:0] conv_en_q;
    reg [`SAMPLE_W-1:0] last_sample_q;

    wire wr_ctl0 = i_wr & (i_addr == `ADDR_PORT_CTL0);
    wire wr_ctl1 = i_wr & (i_addr == `ADDR_PORT_CTL1);
    wire wr_rate = i_wr & (i_addr == `ADDR_BCLK_RATE);
    wire wr_fctl = i_wr & (i_addr == `ADDR_FRAME_CTL);
    wire wr_pull = i_wr & (i_addr == `ADDR_PIN_PULL);
    wire wr_conv = i_wr & (i_addr == `ADDR_CONV_EN);

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            expand_en_q <= 1'b0;
            expand_law_select_q <= 1'b0;
            bclk_dir_q <= 1'b0;
            frame_polarity_variant_select_q <= 1'b0;
            bclk_div_q <= `RST_BCLK_DIV;
            frame_dir_q <= 1'b0;
            frame_rate_q <= `RST_FRAME_RATE;
            pull_q <= 8'h00;
            conv_en_q <= 2'h0;
        end else begin
            if (wr_ctl0) begin
                expand_en_q <= i_wdata[`BIT_EXPAND_EN];
                expand_law_select_q <= i_wdata[`BIT_LAW_SEL];
            end
            if (wr_ctl1) begin
                bclk_dir_q <= i_wdata[`BIT_BCLK_DIR];
                frame_polarity_variant_select_q <= i_wdata[`BIT_VARIANT];
            end
            if (wr_rate) begin
                bclk_div_q <= i_wdata[`BCLK_DIV_MSB:0];
            end
            if (wr_fctl) begin
                frame_dir_q <= i_wdata[`BIT_FRAME_DIR];
                frame_rate_q <= i_wdata[`FRAME_RATE_MSB:0];
            end
            if (wr_pull) begin
                pull_q <= i_wdata[`PULL_MSB:0];
            end
            if (wr_conv) begin
                conv_en_q <= i_wdata[1:0];
            end
        end
    end

    // =========================================
    // register read, data in the following cycle
    reg [`DATA_W-1:0] rd_mux;
    always @* begin
        rd_mux = 16'h0000;
        case (i_addr)
            `ADDR_PORT_CTL0: begin
                rd_mux[`BIT_EXPAND_EN] = expand_en_q;
                rd_mux[`BIT_LAW_SEL] = expand_law_select_q;
            end
            `ADDR_PORT_CTL1: begin
                rd_mux[`BIT_BCLK_DIR] = bclk_dir_q;
                rd_mux[`BIT_VARIANT] = frame_polarity_variant_select_q;
            end
            `ADDR_BCLK_RATE: rd_mux[`BCLK_DIV_MSB:0] = bclk_div_q;
            `ADDR_FRAME_CTL: begin
                rd_mux[`BIT_FRAME_DIR] = frame_dir_q;
                rd_mux[`FRAME_RATE_MSB:0] = frame_rate_q;
            end
            `ADDR_PIN_PULL: rd_mux[`PULL_MSB:0] = pull_q;
            `ADDR_CONV_EN: rd_mux[1:0] = conv_en_q;
            `ADDR_LAST_SAMPLE: rd_mux = last_sample_q;
            default: rd_mux = 16'h0000;
        endcase
    end

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else begin
            o_rdata <= i_rd ? rd_mux : 16'h0000;
        end
    end

    // =========================================
    // bit clock: internal divider or pin
    wire any_conv_on = |conv_en_q;
    wire int_bclk_rise;
    wire int_bclk_level;

    bclk_divider u_bclk_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_run(bclk_dir_q & any_conv_on),
        .i_code(bclk_div_q),
        .o_rise(int_bclk_rise),
        .o_level(int_bclk_level)
    );

    reg ext_bclk_prev_q;
    reg ext_frame_prev_q;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ext_bclk_prev_q <= 1'b0;
        end else begin
            ext_bclk_prev_q <= i_bclk_pin;
        end
    end

    // direction bits alone choose each clock's source
    wire bclk_rise = bclk_dir_q ? int_bclk_rise : (i_bclk_pin & ~ext_bclk_prev_q);

    // =========================================
    // frame clock divided from whichever bit clock
    reg [10:0] frame_cnt_q;
    reg int_frame_q;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            frame_cnt_q <= 11'h000;
            int_frame_q <= 1'b0;
        end else if (!(frame_dir_q & any_conv_on)) begin
            frame_cnt_q <= 11'h000;
            int_frame_q <= 1'b0;
        end else if (bclk_rise) begin
            // one-bit-clock frame pulse every frame_rate bit clocks
            if (frame_cnt_q >= frame_rate_q - 11'h001) begin
                frame_cnt_q <= 11'h000;
                int_frame_q <= 1'b1;
            end else begin
                frame_cnt_q <= frame_cnt_q + 11'h001;
                int_frame_q <= 1'b0;
            end
        end
    end

    wire frame_now = frame_dir_q ? int_frame_q : i_frame_clock_pin;

    // =========================================
    // pin drivers and pulls
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_bclk_pin <= 1'b0;
            o_bclk_oe <= 1'b0;
            o_frame_clock_pin <= 1'b0;
            o_frame_clock_oe <= 1'b0;
            {o_master_clock_pin_pullup, o_master_clock_pin_pulldown} <= 2'h0;
            {o_playback_data_pin_pullup, o_playback_data_pin_pulldown} <= 2'h0;
            {o_frame_clock_pin_pullup, o_frame_clock_pin_pulldown} <= 2'h0;
            {o_bit_clock_pin_pullup, o_bit_clock_pin_pulldown} <= 2'h0;
        end else begin
            o_bclk_pin <= int_bclk_level;
            o_bclk_oe <= bclk_dir_q & any_conv_on;
            o_frame_clock_pin <= int_frame_q;
            o_frame_clock_oe <= frame_dir_q & any_conv_on;
            {o_master_clock_pin_pullup, o_master_clock_pin_pulldown} <= pull_q[7:6];
            {o_playback_data_pin_pullup, o_playback_data_pin_pulldown} <= pull_q[5:4];
            {o_frame_clock_pin_pullup, o_frame_clock_pin_pulldown} <= pull_q[3:2];
            {o_bit_clock_pin_pullup, o_bit_clock_pin_pulldown} <= pull_q[1:0];
        end
    end

    // =========================================
    // 8-bit word capture after each frame rise
    localparam ST_IDLE = 2'h0;
    localparam ST_SKIP = 2'h1;
    localparam ST_LEFT = 2'h2;
    localparam ST_RIGHT = 2'h3;

    wire byte_mode = expand_en_q | expand_law_select_q;
    wire frame_rise = frame_now & ~ext_frame_prev_q;

    reg [1:0] st_q;
    reg [2:0] bit_q;
    reg [6:0] shift_q;
    reg word_done_q;
    reg word_right_q;
    reg [7:0] word_q;

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            ext_frame_prev_q <= 1'b0;
            st_q <= ST_IDLE;
            bit_q <= 3'h0;
            shift_q <= 7'h00;
            word_done_q <= 1'b0;
            word_right_q <= 1'b0;
            word_q <= 8'h00;
        end else begin
            word_done_q <= 1'b0;
            if (!byte_mode) begin
                st_q <= ST_IDLE;
                bit_q <= 3'h0;
            end else if (bclk_rise) begin
                ext_frame_prev_q <= frame_now;
                if (frame_rise) begin
                    // a new frame restarts capture, so words may abut
                    bit_q <= 3'h0;
                    if (frame_polarity_variant_select_q) begin
                        shift_q <= {6'h00, i_playback_serial_data};
                        bit_q <= 3'h1;
                        st_q <= ST_LEFT;
                    end else begin
                        st_q <= ST_SKIP;
                    end
                end else begin
                    case (st_q)
                        ST_IDLE: st_q <= ST_IDLE;
                        ST_SKIP: begin
                            shift_q <= {6'h00, i_playback_serial_data};
                            bit_q <= 3'h1;
                            st_q <= ST_LEFT;
                        end
                        ST_LEFT, ST_RIGHT: begin
                            shift_q <= {shift_q[5:0], i_playback_serial_data};
                            bit_q <= bit_q + 3'h1;
                            if (bit_q == `BITS_PER_WORD) begin
                                word_q <= {shift_q, i_playback_serial_data};
                                word_done_q <= 1'b1;
                                word_right_q <= (st_q == ST_RIGHT);
                                st_q <= (st_q == ST_LEFT) ? ST_RIGHT : ST_IDLE;
                            end
                        end
                        default: st_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // =========================================
    // expansion and sample output
    wire [`SAMPLE_W-1:0] expanded;
    sample_expander u_expander (
        .i_code(word_q),
        .i_expand_en(expand_en_q),
        .i_law_a(expand_law_select_q),
        .o_sample(expanded)
    );

    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_sample <= 16'h0000;
            o_sample_valid <= 1'b0;
            o_sample_right <= 1'b0;
            last_sample_q <= 16'h0000;
        end else begin
            o_sample_valid <= word_done_q;
            if (word_done_q) begin
                o_sample <= expanded;
                o_sample_right <= word_right_q;
                last_sample_q <= expanded;
            end
        end
    end
endmodule // audio_rx_port

//--- verif/audio_rx_port_props.sv
// checker for audio_rx_port: port timing against register shadows
// bound to audio_rx_port; sees its ports only
`timescale 1ns/1ps
module audio_rx_port_props (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [7:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire o_bclk_pin,
    input wire o_bclk_oe,
    input wire o_frame_clock_pin,
    input wire o_frame_clock_oe,
    input wire [15:0] o_sample,
    input wire o_sample_valid
);
    // ==========
    // register shadows, cycles since last write
    logic bdir_q, run_q;
    logic [1:0] mode_q;
    logic [4:0] div_q;
    logic [11:0] fc_q;
    logic [7:0] age_q;
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            bdir_q <= 1'b0;
            run_q <= 1'b0;
            mode_q <= 2'b00;
            div_q <= 5'h04;
            fc_q <= 12'h040;
            age_q <= 8'h00;
        end else begin
            age_q <= i_wr ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
            if (i_wr && i_addr == 8'h18) mode_q <= i_wdata[1:0];
            if (i_wr && i_addr == 8'h19) bdir_q <= i_wdata[6];
            if (i_wr && i_addr == 8'h1a) div_q <= i_wdata[4:0];
            if (i_wr && i_addr == 8'h1b) fc_q <= i_wdata[11:0];
            if (i_wr && i_addr == 8'h30) run_q <= |i_wdata[1:0];
        end
    end
    // ==========
    // properties
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    sequence s_frame_pulse;
        o_frame_clock_pin ##1 !o_frame_clock_pin;
    endsequence
    a_frame_read: assert property (i_rd && i_addr == 8'h1b |=> o_rdata == {4'h0, $past(fc_q)})
        else $error("frame control read mismatch");
    a_bclk_drive: assert property (o_bclk_oe == $past(bdir_q && run_q))
        else $error("bit clock drive mismatch");
    a_frame_drive: assert property (o_frame_clock_oe == $past(fc_q[11] && run_q))
        else $error("frame clock drive mismatch");
    a_bclk_rate: assert property ($rose(o_bclk_pin) && bdir_q && run_q && div_q == 5'h02
        && age_q > 8'd100 |=> !o_bclk_pin ##1 o_bclk_pin) else $error("bit clock period wrong");
    a_frame_rate: assert property ($rose(o_frame_clock_pin) && o_frame_clock_oe && bdir_q
        && div_q == 5'h02 && fc_q == 12'h808 && age_q > 8'd200
        |=> s_frame_pulse ##14 $rose(o_frame_clock_pin)) else $error("frame period wrong");
    a_single_valid: assert property (o_sample_valid |=> !o_sample_valid)
        else $error("sample valid too long");
    a_no_capture: assert property (mode_q == 2'b00 && age_q > 8'd60 |-> !o_sample_valid)
        else $error("capture outside 8-bit mode");
    a_expand_low: assert property (o_sample_valid && mode_q[1] |-> o_sample[1:0] == 2'b00)
        else $error("expanded sample low bits set");
    a_linear_low: assert property (o_sample_valid && mode_q == 2'b01 |-> o_sample[7:0] == 8'h00)
        else $error("linear sample low byte set");
endmodule // audio_rx_port_props
bind audio_rx_port audio_rx_port_props u_props (.*);

//--- verif/host_audio_model.sv
// host audio port: drives bit clock, frame pulse and data as slave master
// clocked from the bench system clock; bit clock period 4 cycles
`timescale 1ns/1ps
module host_audio_model (
    input wire i_clk_sys,
    input wire i_free,
    output logic o_bclk,
    output logic o_frame,
    output logic o_data
);
    logic [1:0] cnt_q = 2'b00;
    initial begin
        o_bclk = 1'b0;
        o_frame = 1'b0;
        o_data = 1'b0;
    end
    // ==========
    // free-running bit clock, mixed operation
    always @(posedge i_clk_sys) begin
        if (i_free) begin
            cnt_q <= cnt_q + 2'b01;
            o_bclk <= cnt_q[1];
        end
    end
    // frame of n bits, msb first; variant a adds a leading rise
    task automatic send(input logic [23:0] w, input int n, input logic vb);
        int k;
        for (int i = 0; i < n + (vb ? 0 : 1); i++) begin
            k = vb ? i : i - 1;
            @(posedge i_clk_sys);
            o_bclk <= 1'b0;
            o_frame <= (i == 0);
            o_data <= (k < 0) ? ~o_data : w[23 - k];
            @(posedge i_clk_sys);
            o_bclk <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            o_bclk <= 1'b0;
        end
        @(posedge i_clk_sys);
        o_data <= ~o_data;
    endtask
endmodule // host_audio_model

//--- verif/audio_rx_port_tb.sv
// self-checking bench for audio_rx_port with a host audio model
// one 200 MHz clock; pins resolved from drive enables
`timescale 1ns/1ps
module audio_rx_port_tb;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic host_free = 1'b0;
    wire [15:0] o_rdata, o_sample;
    wire [7:0] pulls;
    wire o_bclk_pin, o_bclk_oe, o_frame_clock_pin, o_frame_clock_oe, o_sample_valid, o_sample_right;
    wire m_bclk, m_frame, m_data;
    wire bclk_w = o_bclk_oe ? o_bclk_pin : m_bclk;
    wire frame_w = o_frame_clock_oe ? o_frame_clock_pin : m_frame;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    logic [15:0] d;
    logic [16:0] q[$];
    // address, reset value, read back after writing all ones
    localparam logic [39:0] regs [6] = '{40'h18_0000_0003, 40'h19_0000_0050, 40'h1a_0004_001f,
        40'h1b_0040_0fff, 40'h7e_0000_00ff, 40'h44_0000_0000};
    localparam logic [7:0] r2 [21] = '{2, 3, 4, 6, 8, 10, 11, 12, 16, 20, 22, 24, 32, 40, 44, 48, 50, 60, 64, 88, 96};
    // mode, variant, left byte, right byte
    localparam logic [23:0] rows [7] = '{24'h21_00ff, 24'h21_807f, 24'h20_5529, 24'h31_d52a,
        24'h30_0080, 24'h11_817e, 24'h10_ff01};
    localparam int rates [3] = '{8, 9, 2047};
    always #2.5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (o_sample_valid === 1'b1) q.push_back({o_sample_right, o_sample});
    host_audio_model u_host (.i_clk_sys(i_clk_sys), .i_free(host_free), .o_bclk(m_bclk), .o_frame(m_frame),
        .o_data(m_data));
    audio_rx_port dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_bclk_pin(bclk_w), .o_bclk_pin(o_bclk_pin), .o_bclk_oe(o_bclk_oe),
        .i_frame_clock_pin(frame_w), .o_frame_clock_pin(o_frame_clock_pin), .o_frame_clock_oe(o_frame_clock_oe),
        .i_playback_serial_data(m_data), .o_master_clock_pin_pullup(pulls[7]),
        .o_master_clock_pin_pulldown(pulls[6]), .o_playback_data_pin_pullup(pulls[5]),
        .o_playback_data_pin_pulldown(pulls[4]), .o_frame_clock_pin_pullup(pulls[3]),
        .o_frame_clock_pin_pulldown(pulls[2]), .o_bit_clock_pin_pullup(pulls[1]),
        .o_bit_clock_pin_pulldown(pulls[0]), .o_sample(o_sample), .o_sample_valid(o_sample_valid),
        .o_sample_right(o_sample_right));
    // ==========
    // helpers
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // cycles spanning k periods, first rise skipped
    task automatic per(input logic f, input int k, output int c);
        logic p, s;
        int r;
        p = 1'b1;
        r = -2;
        c = 0;
        for (int i = 0; i < 15000 && r < k; i++) begin
            @(posedge i_clk_sys);
            #1 s = f ? o_frame_clock_pin : o_bclk_pin;
            if (s === 1'b1 && p !== 1'b1) r++;
            if (r >= 0) c++;
            p = s;
        end
        c = c - 1;
        if (r < k) begin
            fail_count++;
            stop_test();
        end
    endtask
    function automatic logic [15:0] ex(input logic [3:0] m, input logic [7:0] c);
        logic [7:0] u;
        logic [15:0] t;
        if (m == 4'h1) return {c, 8'h00};
        u = (m == 4'h2) ? ~c : c ^ 8'h55;
        if (m == 4'h2) begin
            t = ({12'h000, u[3:0]} << 3) + 16'h0084;
            t = t << u[6:4];
            return u[7] ? 16'h0084 - t : t - 16'h0084;
        end
        t = {8'h00, u[3:0], 4'h0} + ((u[6:4] == 3'h0) ? 16'h0008 : 16'h0108);
        if (u[6:4] > 3'h1) t = t << (u[6:4] - 3'h1);
        return u[7] ? t : 16'h0000 - t;
    endfunction
    // ==========
    // main sequence
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1 chk({o_bclk_oe, o_frame_clock_oe, pulls}, 10'h000);
        foreach (regs[i]) begin
            rd(regs[i][39:32], d);
            chk(d, regs[i][31:16]);
        end
        foreach (regs[i]) begin
            wr(regs[i][39:32], 16'hffff);
            rd(regs[i][39:32], d);
            chk(d, regs[i][15:0]);
        end
        wr(8'h7e, 16'h00a5);
        @(posedge i_clk_sys);
        #1 chk(pulls, 8'ha5);
        wr(8'h30, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            wr(8'h19, {9'h000, i[1], 6'h00});
            wr(8'h1b, {4'h0, i[0], 11'h008});
            @(posedge i_clk_sys);
            #1 chk({o_bclk_oe, o_frame_clock_oe}, i[1:0]);
        end
        wr(8'h30, 16'h0000);
        @(posedge i_clk_sys);
        #1 chk({o_bclk_oe, o_frame_clock_oe}, 2'b00);
        wr(8'h30, 16'h0002);
        @(posedge i_clk_sys);
        #1 chk({o_bclk_oe, o_frame_clock_oe}, 2'b11);
        for (int c = 2; c < 21; c++) begin
            wr(8'h1a, c[15:0]);
            per(1'b0, 2, n);
            chk(n, r2[c]);
        end
        wr(8'h1a, 16'h0002);
        foreach (rates[i]) begin
            wr(8'h1b, 16'h0800 | rates[i][15:0]);
            per(1'b1, 1, n);
            chk(n, 2 * rates[i]);
        end
        wr(8'h1b, 16'h0808);
        repeat (300) @(posedge i_clk_sys);
        wr(8'h19, 16'h0000);
        host_free <= 1'b1;
        per(1'b1, 1, n);
        chk(n, 32);
        host_free <= 1'b0;
        wr(8'h1b, 16'h0000);
        foreach (rows[i]) begin
            wr(8'h18, {12'h000, rows[i][23:20]});
            wr(8'h19, {11'h000, rows[i][16], 4'h0});
            q.delete();
            u_host.send({rows[i][15:0], 8'ha5}, 24, rows[i][16]);
            repeat (8) @(posedge i_clk_sys);
            chk(q.size(), 2);
            chk(q[0], {1'b0, ex(rows[i][23:20], rows[i][15:8])});
            chk(q[1], {1'b1, ex(rows[i][23:20], rows[i][7:0])});
        end
        wr(8'h18, 16'h0002);
        wr(8'h19, 16'h0010);
        q.delete();
        repeat (2) u_host.send(24'h123400, 16, 1'b1);
        repeat (8) @(posedge i_clk_sys);
        chk(q.size(), 4);
        chk(q[2], {1'b0, ex(4'h2, 8'h12)});
        chk(q[3], {1'b1, ex(4'h2, 8'h34)});
        rd(8'h31, d);
        chk(d, ex(4'h2, 8'h34));
        wr(8'h18, 16'h0000);
        q.delete();
        repeat (70) @(posedge i_clk_sys);
        u_host.send(24'h5a5a00, 16, 1'b1);
        repeat (8) @(posedge i_clk_sys);
        chk(q.size(), 0);
        // reset in mid-run clears pulls and drive enables, restores rate field to 4
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        #1 chk({o_bclk_oe, o_frame_clock_oe, pulls}, 10'h000);
        rd(8'h1a, d);
        chk(d, 16'h0004);
        stop_test();
    end
endmodule // audio_rx_port_tb
